// ===== hw/fsk_pkg.sv
package fsk_pkg;

	// Command codes, matched against the leading bits of the shift register
	localparam logic [3:0]  CODE_CONFIG    = 4'h9;
	localparam logic [3:0]  CODE_FREQ      = 4'ha;
	localparam logic [3:0]  CODE_WAKE      = 4'he;
	localparam logic [7:0]  CODE_POWER     = 8'hc0;
	localparam logic [7:0]  CODE_QSETUP    = 8'hce;
	localparam logic [7:0]  CODE_RATE      = 8'hc8;
	localparam logic [7:0]  CODE_BATT      = 8'hc2;
	localparam logic [7:0]  CODE_WAKE_EXT  = 8'hc3;
	localparam logic [7:0]  CODE_QWRITE    = 8'hc6;

	// Power-on values of the setting registers
	localparam logic [15:0] RST_CONFIG     = 16'h9082;
	localparam logic [15:0] RST_FREQ       = 16'had57;
	localparam logic [15:0] RST_POWER      = 16'hc002;
	localparam logic [15:0] RST_QSETUP     = 16'hce00;
	localparam logic [15:0] RST_RATE       = 16'hc813;
	localparam logic [15:0] RST_BATT       = 16'hc213;
	localparam logic [15:0] RST_WAKE       = 16'he196;
	localparam logic [15:0] RST_WAKE_EXT   = 16'hc300;

	// Channel word limits
	localparam logic [11:0] CHAN_MIN       = 12'h060;
	localparam logic [11:0] CHAN_MAX       = 12'hf3f;

	// Band constants
	localparam logic [3:0]  BAND_C_LOW     = 4'ha;
	localparam logic [3:0]  BAND_C_HIGH    = 4'hb;

	// Bit positions inside the power command
	localparam int          POW_XTAL       = 5;
	localparam int          POW_SYNTH      = 4;
	localparam int          POW_PA         = 3;
	localparam int          POW_BATT       = 2;
	localparam int          POW_WAKE       = 1;
	localparam int          POW_CLKOFF     = 0;

	// Queue
	localparam int          QUEUE_DEPTH    = 64;
	localparam int          BUF_DEPTH      = 32;
	localparam int          QSETUP_EN      = 7;
	localparam int          BATT_LFCLK     = 4;

	// Bit clock: system clock cycles per 10 MHz reference tick
	localparam int          CLK_MHZ        = 100;
	localparam int          REF_MHZ        = 10;
	localparam int          REF_DIV        = CLK_MHZ / REF_MHZ;
	localparam int          RATE_PRE       = 29;
	localparam int          RATE_CS_MUL    = 8;

	// Wake timer: reference ticks per millisecond
	localparam int          MS_TICKS       = REF_MHZ * 1000;

	typedef enum logic [1:0]
	{
		FSK_STANDBY = 2'b00,
		FSK_SLEEP   = 2'b01,
		FSK_IDLE    = 2'b10,
		FSK_ACTIVE  = 2'b11
	} fsk_mode_type;

endpackage

// ===== hw/fsk_tx_command_set.sv
// Overview of operation
// R01: Serial bits enter MSB first on rising clock while select low; high resets.
// R02: Commands are whole octets, except queue write carrying any data bits.
// R03: Band constant is 10 for band bit 0 and 11 for band bit 1.
// R04: Three-bit power field steps output down by 3 dB per code.
// R05: Deviation (M+1)*20 kHz, direction is sign bit XOR modulation pin.
// R06: Twelve-bit channel word sets centre as 80 MHz times (C + F/4000).
// R07: Channel words outside 96..3903 are ignored, old value kept.
// R08: Power command bits enable oscillator, synth, battery, timer; bit 0 clock off.
// R09: Amplifier enable also forces oscillator and synthesizer on.
// R10: With queue mode, amplifier enable starts shifting the queue out.
// R11: Mode: active, idle, sleep or standby derived from the enables.
// R12: Host should keep oscillator and synth on, toggling only amplifier.
// R13: Data bits after queue write header load the queue in queue mode.
// R14: Without queue, host enables amplifier then drives modulation pin.
// R15: Host waits oscillator start and lock before valid transmit data.
// R16: Queue setup bit 7 enables 64-bit queue; clearing it empties it.
// R17: Queue interrupt raised when remaining bits reach six-bit threshold.
// R18: Bit clock is 10 MHz / 29 / (R+1) / (cs ? 8 : 1).
// R19: Battery threshold is 2.0 V plus T times 0.1 V.
// R20: Battery command bit 4 enables slow host clock during sleep.
// R21: Three-bit divider selects host clock from 1 MHz up to 10 MHz.
// R22: Wake period M*2^(R-D) ms, M split over two commands.
// R23: Wake interrupt repeats once per period while timer enabled.
// R24: Settings update only once the full command length is shifted in.
`timescale 1ns/1ps

////////////////////////////////////////////////////////////////////////////////
module fsk_fifo
	#(
		parameter int WIDTH = 1,
		parameter int DEPTH = 32
	)
	(
		input  wire logic             clock,
		input  wire logic             rst,
		input  wire logic             flush,
		input  wire logic [WIDTH-1:0] in_data,
		input  wire logic             in_valid,
		output logic                  in_ready,
		output logic      [WIDTH-1:0] out_data,
		output logic                  out_valid,
		input  wire logic             out_ready
	);

	localparam int AW = $clog2(DEPTH);

	logic [WIDTH-1:0] mem [DEPTH];
	logic [AW-1:0]    wr_ptr;
	logic [AW-1:0]    rd_ptr;
	logic [AW:0]      count;
	wire              push = in_valid && in_ready;
	wire              pop  = out_valid && out_ready;

	// Honest full and empty from the occupancy count
	assign in_ready  = (count != (AW+1)'(DEPTH));
	assign out_valid = (count != '0);
	assign out_data  = mem[rd_ptr];

	// Storage write
	always_ff @(posedge clock)
	begin
		if (push)
			mem[wr_ptr] <= in_data;
	end

	// Pointers and count; flush drops everything
	always_ff @(posedge clock)
	begin
		if (rst || flush)
		begin
			wr_ptr <= '0;
			rd_ptr <= '0;
			count  <= '0;
		end
		else
		begin
			if (push)
				wr_ptr <= wr_ptr + AW'(1);
			if (pop)
				rd_ptr <= rd_ptr + AW'(1);
			count <= count + (AW+1)'(push) - (AW+1)'(pop);
		end
	end

endmodule

////////////////////////////////////////////////////////////////////////////////
module fsk_tx_command_set
	import fsk_pkg::*;
	(
		input  wire logic        clock,
		input  wire logic        rst,
		input  wire logic        link_enable_low,
		input  wire logic        serial_clock,
		input  wire logic        serial_in,
		input  wire logic        modulation_in,
		output logic             band_choice,
		output logic [3:0]       band_constant,
		output logic [2:0]       power_level,
		output logic [3:0]       xtal_load,
		output logic             deviation_sign,
		output logic [2:0]       deviation_magnitude,
		output logic             deviation_up,
		output logic [11:0]      channel_word,
		output logic             xtal_osc_on,
		output logic             synth_on,
		output logic             amp_on,
		output logic             batt_monitor_enable,
		output logic             wake_timer_enable,
		output logic             clock_out_disable,
		output fsk_mode_type     mode,
		output logic             tx_queue_enable,
		output logic [5:0]       queue_threshold,
		output logic             queue_irq,
		output logic [6:0]       rate_divisor,
		output logic             rate_prescale,
		output logic             bit_tick,
		output logic             tx_data,
		output logic [3:0]       batt_threshold,
		output logic             slow_clock_enable,
		output logic [2:0]       host_clock_divide,
		output logic [13:0]      wake_mantissa,
		output logic [3:0]       wake_exponent,
		output logic [1:0]       wake_exponent_reduce,
		output logic             wake_irq
	);

	////////////////////////////////////////////////////////////////////////
	// Pin synchronisers
	logic [3:0] sync_a;
	logic [3:0] sync_b;
	logic       sck_last;

	always_ff @(posedge clock)
	begin
		sync_a <= {link_enable_low, serial_clock, serial_in, modulation_in};
		sync_b <= sync_a;
	end

	wire sel_low  = !sync_b[3];
	wire sck      = sync_b[2];
	wire sdi      = sync_b[1];
	wire mod_pin  = sync_b[0];

	always_ff @(posedge clock)
	begin
		sck_last <= rst ? 1'b0 : sck;
	end

	wire sck_rise = sel_low && sck && !sck_last; // R01

	////////////////////////////////////////////////////////////////////////
	// Shift register and decode
	logic [15:0] shreg;
	logic [4:0]  nbits;
	logic        in_qwrite;
	logic [15:0] cfg;
	logic [15:0] pwr;
	logic [15:0] qset;
	logic [15:0] rate;
	logic [15:0] batt;
	logic [15:0] wake;
	logic [15:0] wake_ext;
	logic [11:0] chan;

	wire [15:0] word     = {shreg[14:0], sdi};
	wire        last16   = sck_rise && !in_qwrite && nbits == 5'd15; // R24
	wire        hdr8     = sck_rise && !in_qwrite && nbits == 5'd7
	                       && word[7:0] == CODE_QWRITE;
	wire        q_bit    = sck_rise && in_qwrite; // R02
	wire [11:0] new_chan = word[11:0];
	wire        chan_ok  = new_chan >= CHAN_MIN && new_chan <= CHAN_MAX; // R07
	wire        wr_cfg   = last16 && word[15:12] == CODE_CONFIG; // R03
	wire        wr_freq  = last16 && word[15:12] == CODE_FREQ;
	wire        wr_wake  = last16 && word[15:12] == CODE_WAKE;
	wire        wr_pwr   = last16 && word[15:8] == CODE_POWER;
	wire        wr_qset  = last16 && word[15:8] == CODE_QSETUP;
	wire        wr_rate  = last16 && word[15:8] == CODE_RATE;
	wire        wr_batt  = last16 && word[15:8] == CODE_BATT;
	wire        wr_wext  = last16 && word[15:8] == CODE_WAKE_EXT;

	// Bit counter; select high reinitialises the port
	always_ff @(posedge clock)
	begin
		if (rst || !sel_low)
		begin
			shreg     <= '0;
			nbits     <= '0;
			in_qwrite <= 1'b0; // R01
		end
		else if (sck_rise)
		begin
			shreg <= word; // R01
			if (hdr8)
				in_qwrite <= 1'b1; // R02
			if (!in_qwrite)
				nbits <= (nbits == 5'd15) ? 5'd0 : nbits + 5'd1;
		end
	end

	// Setting registers
	always_ff @(posedge clock)
	begin
		if (rst)
		begin
			cfg      <= RST_CONFIG;
			chan     <= RST_FREQ[11:0];
			pwr      <= RST_POWER;
			qset     <= RST_QSETUP;
			rate     <= RST_RATE;
			batt     <= RST_BATT;
			wake     <= RST_WAKE;
			wake_ext <= RST_WAKE_EXT;
		end
		else
		begin
			if (wr_cfg)
				cfg <= word;
			if (wr_freq && chan_ok)
				chan <= new_chan; // R07
			if (wr_pwr)
				pwr <= word; // R08
			if (wr_qset)
				qset <= word;
			if (wr_rate)
				rate <= word;
			if (wr_batt)
				batt <= word;
			if (wr_wake)
				wake <= word;
			if (wr_wext)
				wake_ext <= word; // R22
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Field outputs
	assign band_choice         = cfg[11];
	assign band_constant       = band_choice ? BAND_C_HIGH : BAND_C_LOW; // R03
	assign power_level         = cfg[10:8]; // R04
	assign xtal_load           = cfg[7:4];
	assign deviation_sign      = cfg[3];
	assign deviation_magnitude = cfg[2:0];
	assign deviation_up        = deviation_sign ^ mod_pin; // R05
	assign channel_word        = chan; // R06
	assign amp_on              = pwr[POW_PA];
	assign xtal_osc_on         = pwr[POW_XTAL] || amp_on; // R09
	assign synth_on            = pwr[POW_SYNTH] || amp_on; // R09
	assign batt_monitor_enable = pwr[POW_BATT]; // R08
	assign wake_timer_enable   = pwr[POW_WAKE]; // R08
	assign clock_out_disable   = pwr[POW_CLKOFF]; // R08
	assign tx_queue_enable     = qset[QSETUP_EN]; // R16
	assign queue_threshold     = qset[5:0];
	assign rate_prescale       = rate[7];
	assign rate_divisor        = rate[6:0];
	assign batt_threshold      = batt[3:0]; // R19
	assign host_clock_divide   = batt[7:5]; // R21
	assign wake_mantissa       = {wake_ext[5:0], wake[7:0]}; // R22
	assign wake_exponent       = wake[11:8];
	assign wake_exponent_reduce = wake_ext[7:6];

	// Mode from the enables; sleep keeps slow clock only if asked
	wire [1:0] mode_code = amp_on ? FSK_ACTIVE :
	                       pwr[POW_XTAL] ? FSK_IDLE :
	                       (pwr[POW_BATT] || pwr[POW_WAKE]) ? FSK_SLEEP :
	                       FSK_STANDBY; // R11
	assign mode = fsk_mode_type'(mode_code);
	assign slow_clock_enable = batt[BATT_LFCLK] && mode == FSK_SLEEP; // R20

	////////////////////////////////////////////////////////////////////////
	// Bit clock: reference tick, then /29, /(R+1), /8 if prescaled
	logic [3:0]  ref_cnt;
	logic [4:0]  pre_cnt;
	logic [6:0]  r_cnt;
	logic [2:0]  cs_cnt;
	wire         ref_tick = ref_cnt == 4'(REF_DIV - 1);
	wire         pre_tick = ref_tick && pre_cnt == 5'(RATE_PRE - 1);
	// At-or-above, so a smaller divisor written mid-count cannot stall
	wire         r_tick   = pre_tick && r_cnt >= rate_divisor;
	wire [2:0]   cs_top   = rate_prescale ? 3'(RATE_CS_MUL - 1) : 3'h0;
	wire         br_tick  = r_tick && cs_cnt >= cs_top; // R18

	always_ff @(posedge clock)
	begin
		if (rst)
		begin
			ref_cnt <= '0;
			pre_cnt <= '0;
			r_cnt   <= '0;
			cs_cnt  <= '0;
			bit_tick <= 1'b0;
		end
		else
		begin
			ref_cnt <= ref_tick ? 4'h0 : ref_cnt + 4'h1;
			if (ref_tick)
				pre_cnt <= pre_tick ? 5'h0 : pre_cnt + 5'h1;
			if (pre_tick)
				r_cnt <= r_tick ? 7'h0 : r_cnt + 7'h1;
			if (r_tick)
				cs_cnt <= br_tick ? 3'h0 : cs_cnt + 3'h1;
			bit_tick <= br_tick; // R18
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Transmit queue: a 32-entry buffer feeding the 64-bit shift queue
	logic        buf_valid;
	logic        buf_data;
	logic        buf_in_ready;
	logic [63:0] queue;
	logic [6:0]  q_count;
	wire         q_room   = q_count != 7'(QUEUE_DEPTH);
	wire         q_take   = buf_valid && q_room;
	wire         shifting = tx_queue_enable && amp_on; // R10
	wire         q_out    = shifting && bit_tick && q_count != 7'h0;

	// Ignored while queue mode is off; buffer stalls when queue is full
	fsk_fifo #(.WIDTH(1), .DEPTH(BUF_DEPTH)) u_buf
	(
		.clock     (clock),
		.rst       (rst),
		.flush     (!tx_queue_enable),
		.in_data   (sdi),
		.in_valid  (q_bit && tx_queue_enable), // R13
		.in_ready  (buf_in_ready),
		.out_data  (buf_data),
		.out_valid (buf_valid),
		.out_ready (q_room)
	);

	// Shift queue; MSB-first out, clearing enable empties it
	always_ff @(posedge clock)
	begin
		if (rst || !tx_queue_enable)
		begin
			queue   <= '0;
			q_count <= '0; // R16
		end
		else
		begin
			if (q_take)
				queue[6'(q_count - 7'(q_out))] <= buf_data; // R13
			if (q_out)
				queue <= {1'b0, queue[63:1]};
			if (q_out && q_take)
				queue <= {1'b0, queue[63:1]}
				         | (64'(buf_data) << (q_count - 7'h1));
			q_count <= q_count + 7'(q_take) - 7'(q_out);
		end
	end

	// Outgoing data: queue head in queue mode, else the modulation pin
	always_ff @(posedge clock)
	begin
		if (rst)
			tx_data <= 1'b0;
		else if (q_out)
			tx_data <= queue[0]; // R10
		else if (!tx_queue_enable)
			tx_data <= mod_pin; // R14
	end

	always_ff @(posedge clock)
	begin
		queue_irq <= !rst && tx_queue_enable
		             && q_count == {1'b0, queue_threshold}; // R17
	end

	////////////////////////////////////////////////////////////////////////
	// Wake timer: ms tick, then M * 2^(R-D) ms; exponent floored at 0
	logic [16:0] ms_cnt;
	logic [31:0] w_cnt;
	wire  [4:0]  w_exp  = (wake_exponent >= 4'(wake_exponent_reduce)) ?
	                      5'(wake_exponent - 4'(wake_exponent_reduce)) : 5'h0;
	wire  [31:0] w_top  = 32'(wake_mantissa) << w_exp; // R22
	wire         ms_tick = ms_cnt == 17'(MS_TICKS * REF_DIV - 1);
	wire         w_hit  = ms_tick && w_cnt + 32'h1 >= w_top;

	always_ff @(posedge clock)
	begin
		if (rst || !wake_timer_enable)
		begin
			ms_cnt   <= '0;
			w_cnt    <= '0;
			wake_irq <= 1'b0;
		end
		else
		begin
			ms_cnt   <= ms_tick ? 17'h0 : ms_cnt + 17'h1;
			if (ms_tick)
				w_cnt <= w_hit ? 32'h0 : w_cnt + 32'h1;
			wake_irq <= w_hit && w_top != 32'h0; // R23
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Checks
	sequence s_full_word;
		last16 && word[15:12] == CODE_FREQ && chan_ok;
	endsequence

	a_chan_load: assert property (@(posedge clock) disable iff (rst)
		s_full_word |=> channel_word == $past(new_chan)) // R06
		else $error("channel word not loaded");
	a_chan_range: assert property (@(posedge clock) disable iff (rst)
		(wr_freq && !chan_ok) |=> $stable(channel_word)) // R07
		else $error("out of range channel accepted");
	a_pa_forces: assert property (@(posedge clock) disable iff (rst)
		amp_on |-> xtal_osc_on && synth_on && mode == FSK_ACTIVE) // R09
		else $error("amplifier did not force oscillators");
	a_mode_sleep: assert property (@(posedge clock) disable iff (rst)
		(!pwr[POW_PA] && !pwr[POW_XTAL] && !pwr[POW_SYNTH] &&
		 pwr[POW_WAKE]) |-> mode == FSK_SLEEP) // R11
		else $error("sleep mode wrong");
	a_queue_clear: assert property (@(posedge clock) disable iff (rst)
		!tx_queue_enable |=> q_count == 7'h0) // R16
		else $error("queue not emptied");
	a_select_init: assert property (@(posedge clock) disable iff (rst)
		!sel_low |=> nbits == 5'h0 && !in_qwrite) // R01
		else $error("port not reinitialised");
	a_no_partial: assert property (@(posedge clock) disable iff (rst)
		(sck_rise && nbits != 5'd15) |=> $stable(pwr) && $stable(cfg)) // R24
		else $error("setting changed mid command");
	a_band_const: assert property (@(posedge clock) disable iff (rst)
		band_constant == (band_choice ? 4'hb : 4'ha)) // R03
		else $error("band constant wrong");
	a_dev_dir: assert property (@(posedge clock) disable iff (rst)
		deviation_up == (deviation_sign ^ mod_pin)) // R05
		else $error("deviation direction wrong");

endmodule

// ===== verification/fsk_host_model.sv
`timescale 1ns/1ps

////////////////////////////////////////////////////////////////////////////////
module fsk_host_model
	(
		input  wire logic clock,
		output logic      link_enable_low,
		output logic      serial_clock,
		output logic      serial_in,
		output logic      modulation_in
	);

	// Idle: select high, serial clock parked low
	initial
	begin
		link_enable_low = 1'b1;
		serial_clock = 1'b0;
		serial_in = 1'b0;
		modulation_in = 1'b0;
	end

	// One select frame of n bits, MSB first; four clocks per half period
	// so the design's synchronisers never miss an edge
	task automatic frame(input logic [31:0] v, input int n);
		int i;
		@(negedge clock);
		link_enable_low = 1'b0;
		repeat (4) @(negedge clock);
		for (i = n - 1; i >= 0; i--)
		begin
			serial_in = v[i];
			repeat (4) @(negedge clock);
			serial_clock = 1'b1;
			repeat (4) @(negedge clock);
			serial_clock = 1'b0;
		end
		repeat (4) @(negedge clock);
		link_enable_low = 1'b1;
		serial_in = ~serial_in; // Released line: stale bit must not linger
		repeat (8) @(negedge clock);
	endtask

	// Direct modulation; waits six cycles before the caller trusts the carrier
	task automatic set_mod(input logic level);
		@(negedge clock);
		modulation_in = level;
		repeat (6) @(negedge clock);
	endtask
endmodule

// ===== verification/tb_fsk_tx_command_set.sv
`timescale 1ns/1ps

////////////////////////////////////////////////////////////////////////////////
module tb_fsk_tx_command_set
	import fsk_pkg::*;
	;

	logic         clock = 1'b0;
	logic         rst = 1'b1;
	logic         link_enable_low, serial_clock, serial_in, modulation_in;
	logic         band_choice, deviation_sign, deviation_up;
	logic [3:0]   band_constant, xtal_load, batt_threshold, wake_exponent;
	logic [2:0]   power_level, deviation_magnitude, host_clock_divide;
	logic [11:0]  channel_word;
	logic         xtal_osc_on, synth_on, amp_on, batt_monitor_enable;
	logic         wake_timer_enable, clock_out_disable, tx_queue_enable;
	fsk_mode_type mode;
	logic [5:0]   queue_threshold;
	logic         queue_irq, rate_prescale, bit_tick, tx_data;
	logic [6:0]   rate_divisor;
	logic         slow_clock_enable, wake_irq;
	logic [13:0]  wake_mantissa;
	logic [1:0]   wake_exponent_reduce;
	logic [15:0]  cfg = RST_CONFIG, frq = RST_FREQ, pwr = RST_POWER;
	logic [15:0]  qs = RST_QSETUP, rt = RST_RATE, bt = RST_BATT;
	logic [15:0]  wk = RST_WAKE, wx = RST_WAKE_EXT;
	logic         irq_seen = 1'b0;
	logic         wake_seen = 1'b0;
	logic         take_bit = 1'b0;
	logic [7:0]   got = 8'h0;
	int           n_got = 0;
	int           n_mismatch = 0;
	int           n_tests = 0;
	int           cycles = 0;
	int           i, k;
	logic [15:0]  chan_tab[7] = '{16'ha060, 16'haf3f, 16'ha05f, 16'haf40,
	                              16'ha000, 16'hafff, 16'ha123};
	logic [15:0]  pow_tab[7] = '{16'hc020, 16'hc000, 16'hc004, 16'hc002,
	                             16'hc008, 16'hc001, 16'hc028};

	always #5 clock = ~clock;

	fsk_host_model u_host (.clock(clock), .link_enable_low(link_enable_low),
		.serial_clock(serial_clock), .serial_in(serial_in),
		.modulation_in(modulation_in));

	fsk_tx_command_set dut (.clock(clock), .rst(rst),
		.link_enable_low(link_enable_low), .serial_clock(serial_clock),
		.serial_in(serial_in), .modulation_in(modulation_in),
		.band_choice(band_choice), .band_constant(band_constant),
		.power_level(power_level), .xtal_load(xtal_load),
		.deviation_sign(deviation_sign),
		.deviation_magnitude(deviation_magnitude),
		.deviation_up(deviation_up), .channel_word(channel_word),
		.xtal_osc_on(xtal_osc_on), .synth_on(synth_on), .amp_on(amp_on),
		.batt_monitor_enable(batt_monitor_enable),
		.wake_timer_enable(wake_timer_enable),
		.clock_out_disable(clock_out_disable), .mode(mode),
		.tx_queue_enable(tx_queue_enable),
		.queue_threshold(queue_threshold), .queue_irq(queue_irq),
		.rate_divisor(rate_divisor), .rate_prescale(rate_prescale),
		.bit_tick(bit_tick), .tx_data(tx_data),
		.batt_threshold(batt_threshold),
		.slow_clock_enable(slow_clock_enable),
		.host_clock_divide(host_clock_divide),
		.wake_mantissa(wake_mantissa), .wake_exponent(wake_exponent),
		.wake_exponent_reduce(wake_exponent_reduce), .wake_irq(wake_irq));

	////////////////////////////////////////////////////////////////////////
	// Verdict, printed once from here only
	task automatic final_report;
		$display("checks %0d mismatches %0d", n_tests, n_mismatch);
		if (n_mismatch == 0 && n_tests > 0)
			$display("STATUS OK");
		else
			$display("STATUS NOT OK");
		$finish;
	endtask

	// Hang guard; the whole sequence needs well under this
	always @(posedge clock)
	begin
		cycles++;
		if (cycles == 30000)
		begin
			n_mismatch++;
			final_report();
		end
	end

	// Threshold crossing is a level, so latch any sighting
	always @(posedge clock)
	begin
		if (queue_irq === 1'b1)
			irq_seen <= 1'b1;
		if (wake_irq === 1'b1)
			wake_seen <= 1'b1;
	end

	// A shifted bit settles one cycle after its tick; the first tick may
	// fall in the command's own tail, so bits are captured by event
	always @(negedge clock)
	begin
		take_bit <= bit_tick === 1'b1 && amp_on === 1'b1
		            && tx_queue_enable === 1'b1;
		if (take_bit && n_got < 8)
		begin
			got   <= {got[6:0], tx_data};
			n_got <= n_got + 1;
		end
	end

	task automatic check(input string what, input logic [15:0] e,
		input logic [15:0] s);
		n_tests++;
		if (s !== e)
		begin
			n_mismatch++;
			$display("CHECK FAILED %s expected %h seen %h", what, e, s);
		end
	endtask

	// Operating mode from enables; amplifier wins over everything
	function automatic logic [1:0] exp_mode(input logic [15:0] p);
		if (p[3])
			return 2'h3;
		if (p[5])
			return 2'h2;
		return (p[2] | p[1]) ? 2'h1 : 2'h0;
	endfunction

	// Every setting is compared after every cmd write to catch side effects
	task automatic check_all;
		check("config", {4'h0, cfg[11:0]}, {4'h0, band_choice, power_level,
			xtal_load, deviation_sign, deviation_magnitude});
		check("band", {12'h0, cfg[11] ? 4'hb : 4'ha},
			{12'h0, band_constant});
		check("channel", {4'h0, frq[11:0]}, {4'h0, channel_word});
		check("power", {8'h0, exp_mode(pwr), pwr[5] | pwr[3], pwr[4] | pwr[3],
			pwr[3:0]}, {8'h0, mode, xtal_osc_on, synth_on, amp_on,
			batt_monitor_enable, wake_timer_enable,
			clock_out_disable});
		check("queue setup", {8'h0, qs[7], 1'b0, qs[5:0]},
			{8'h0, tx_queue_enable, 1'b0, queue_threshold});
		check("rate", {8'h0, rt[7:0]},
			{8'h0, rate_prescale, rate_divisor});
		check("battery", {8'h0, bt[7:5], bt[4] & (exp_mode(pwr) == 2'h1),
			bt[3:0]}, {8'h0, host_clock_divide, slow_clock_enable,
			batt_threshold});
		check("wake", {wx[7:0], wk[7:0]},
			{wake_exponent_reduce, wake_mantissa});
		check("wake exp", {12'h0, wk[11:8]}, {12'h0, wake_exponent});
	endtask

	// Expected register image, keyed on the leading code bits
	task automatic shadow(input logic [15:0] w);
		if (w[15:12] == CODE_CONFIG)
			cfg = w;
		else if (w[15:12] == CODE_FREQ)
		begin
			if (w[11:0] >= 12'h060 && w[11:0] <= 12'hf3f)
				frq = w;
		end
		else if (w[15:12] == CODE_WAKE)
			wk = w;
		else
			case (w[15:8])
				CODE_POWER:    pwr = w;
				CODE_QSETUP:   qs = w;
				CODE_RATE:     rt = w;
				CODE_BATT:     bt = w;
				CODE_WAKE_EXT: wx = w;
				default:       ;
			endcase
	endtask

	task automatic cmd(input logic [15:0] w);
		u_host.frame({16'h0, w}, 16);
		shadow(w);
		check_all();
	endtask

	////////////////////////////////////////////////////////////////////////
	// Main sequence
	initial
	begin
		repeat (4) @(negedge clock);
		rst = 1'b0;
		repeat (3) @(negedge clock);
		check_all();
		$display("test reset done");
		for (i = 0; i < 8; i++)
		begin
			cmd({4'h9, i[0], 3'(i), 4'(7 - i), i[1], 3'(i)});
			u_host.set_mod(i[2]);
			check("deviation dir", {15'h0, i[1] ^ i[2]},
				{15'h0, deviation_up});
		end
		$display("test config done");
		foreach (chan_tab[j])
			cmd(chan_tab[j]);
		$display("test channel done");
		u_host.frame({24'h0, 8'h9f}, 8);
		check_all();
		u_host.frame({16'hc8ff, 16'hc2f5}, 32);
		shadow(16'hc8ff);
		shadow(16'hc2f5);
		check_all();
		cmd(16'he3a5);
		cmd(16'hc3bf);
		$display("test framing done");
		foreach (pow_tab[j])
			cmd(pow_tab[j]);
		$display("test power done");
		cmd(16'hc038);
		u_host.set_mod(1'b1);
		check("direct tx 1", 16'h1, {15'h0, tx_data});
		u_host.set_mod(1'b0);
		check("direct tx 0", 16'h0, {15'h0, tx_data});
		$display("test direct done");
		cmd(16'hc800);
		cmd(16'hc020);
		cmd(16'hce84);
		u_host.frame({20'h0, 8'hc6, 4'hb}, 12);
		check("irq at level", 16'h1, {15'h0, queue_irq});
		cmd(16'hce04);
		check("irq disabled", 16'h0, {15'h0, queue_irq});
		cmd(16'hce84);
		check("irq emptied", 16'h0, {15'h0, queue_irq});
		u_host.frame({16'h0, 8'hc6, 8'hb2}, 16);
		check("irq above", 16'h0, {15'h0, queue_irq});
		irq_seen = 1'b0;
		cmd(16'hc028);
		for (i = 7; i >= 0; i--)
		begin
			k = 0;
			do
			begin
				@(posedge clock);
				k++;
			end
			while (bit_tick !== 1'b1 && k < 400);
			check("tick wait", 16'h0, {15'h0, k >= 400});
			repeat (10) @(negedge clock);
		end
		for (i = 7; i >= 0; i--)
			check("queue bit", {15'h0, 1'(8'hb2 >> i)},
				{15'h0, got[i]});
		check("queue length", 16'h8, n_got[15:0]);
		check("irq crossed", 16'h1, {15'h0, irq_seen});
		check("irq drained", 16'h0, {15'h0, queue_irq});
		check("wake quiet", 16'h0, {15'h0, wake_seen});
		$display("test queue done");
		final_report();
	end
endmodule
